// ===== include/rfa_pkg.sv
// Purpose: Shared constants for the receive interrupt and automatic acknowledgement block.
// Assumes: 32-bit APB with word-aligned registers; one clock domain.
// Notes:   Offsets are byte addresses.
package rfa_pkg;
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_ACK_DELAY  = 8'h04;
   localparam logic [7:0]  OFS_PENDING    = 8'h08;
   localparam logic [7:0]  OFS_IRQ_STATUS = 8'h0c;
   localparam logic [7:0]  OFS_IRQ_CLEAR  = 8'h10;
   localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h14;
   localparam logic [7:0]  OFS_STATUS     = 8'h18;

   // Control register fields.
   localparam int          CTRL_ADDR_FILTER_UNIT_ENABLE_LSB  = 0;
   localparam int          CTRL_PROM      = 4;
   localparam int          CTRL_AUTO_ACKNOWLEDGE      = 5;
   localparam int          CTRL_RATE_RX   = 6;
   localparam int          CTRL_FCS_RX    = 7;
   localparam int          CTRL_SRC_BUF   = 8;
   localparam int          CTRL_FCS32_CFG = 9;
   localparam int          CTRL_TRANSMIT_THEN_LISTEN     = 10;
   localparam int          CTRL_WIDTH     = 11;

   localparam logic [CTRL_WIDTH-1:0] CTRL_RST      = 11'h000;
   localparam logic [15:0]           ACK_DELAY_RST = 16'h0000;
   localparam logic [3:0]            PENDING_RST   = 4'h0;

   // Interrupt bit positions.
   localparam int          IRQ_RXFS       = 0;
   localparam int          IRQ_RXAM       = 1;
   localparam int          IRQ_RXEM       = 2;
   localparam int          IRQ_RXFE       = 3;
   localparam int          IRQ_TX_FRAME_END_IRQ       = 4;
   localparam int          IRQ_WIDTH      = 5;
   localparam logic [IRQ_WIDTH-1:0] IRQ_RST = 5'h00;

   // Frame types and acknowledgement frame layout.
   localparam logic [2:0]  FT_DATA        = 3'h1;
   localparam logic [2:0]  FT_ACK         = 3'h2;
   localparam logic [2:0]  FT_CMD         = 3'h3;
   localparam logic [7:0]  ACK_FCF_LO     = 8'h02;
   localparam logic [7:0]  ACK_FCF_HI     = 8'h00;
   localparam int          FCF_PEND_BIT   = 4;
   localparam logic [2:0]  ACK_LEN_FCS16  = 3'h5;
   localparam logic [2:0]  ACK_LEN_FCS32  = 3'h7;
   localparam logic [15:0] CRC16_POLY     = 16'h8408;
   localparam logic [31:0] CRC32_POLY     = 32'hedb88320;
   localparam logic [31:0] CRC32_INIT     = 32'hffffffff;

   typedef enum logic [1:0] {
      RFA_IDLE,
      RFA_WAIT,
      RFA_SEND
   } rfa_state_t;
endpackage

// ===== core/rfa_core.sv
// Purpose: Receive-frame interrupt decision and automatic acknowledgement control behind an APB slave.
// Assumes: Baseband event inputs are single-cycle pulses on pclk; no synchronisation needed.
// Notes:   Acknowledgement delay counts pclk cycles.
// Contract
// [RULE1] Frame-start interrupt on every valid header, whatever the filters say.
// [RULE2] Filter enabled and address rules met raises address-match interrupt.
// [RULE3] Filter enabled and extended rules met raises extended-match interrupt.
// [RULE4] Frame-end interrupt marks the whole frame stored and ready for host.
// [RULE5] Frame-end interrupt suppressed unless every applicable filter stage passed.
// [RULE6] All units disabled: no match interrupts; frame-end follows first-level pass.
// [RULE7] Filter enabled: frame-end needs first-level pass and match, extended or promiscuous.
// [RULE8] Acknowledgement frames raise frame-end without either match interrupt.
// [RULE9] Auto acknowledge only for matched data or command frames requesting one.
// [RULE10] Sequence number and acknowledgement checksum are produced by this block.
// [RULE11] Host programs delay from frame end to acknowledgement start.
// [RULE12] Acknowledgement rate comes from received frame or transmit settings.
// [RULE13] Content comes from internal generation or host-filled transmit buffer.
// [RULE14] Checksum type comes from received frame or configuration.
// [RULE15] Host should not enable auto acknowledge together with transmit-then-listen.
// [RULE16] Internal acknowledgement copies sequence; 5 octets with 16-bit, 7 with 32-bit.
// [RULE17] Frame-pending bit taken from pending setting of the matching unit.
// [RULE18] Acknowledgement starts the programmed delay after frame-end interrupt; the code starts it one cycle later (delay plus one).
// [RULE19] Sent acknowledgement raises transmit-end; otherwise finish in transmit-prepare.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module rfa_core
   import rfa_pkg::*;
#(
   parameter int RATE_W = 4
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              rx_header_valid,
   input  wire logic              rx_header_parsed,
   input  wire logic [3:0]        addr_match_result,
   input  wire logic              extended_match_result,
   input  wire logic [2:0]        rx_frame_type,
   input  wire logic              rx_ack_request,
   input  wire logic [7:0]        rx_seq_num,
   input  wire logic              rx_fcs32,
   input  wire logic [RATE_W-1:0] rx_rate,
   input  wire logic [RATE_W-1:0] tx_cfg_rate,
   input  wire logic              rx_frame_done,
   input  wire logic              first_level_pass,
   input  wire logic              ack_tx_done,
   output logic                   rx_frame_start_irq,
   output logic                   rx_address_match_irq,
   output logic                   rx_extended_match_irq,
   output logic                   rx_frame_end_irq,
   output logic                   tx_frame_end_irq,
   output logic                   irq,
   output logic                   transmit_prepare_state,
   output logic                   ack_tx_start,
   output logic                   ack_from_buffer,
   output logic [RATE_W-1:0]      ack_rate,
   output logic                   ack_fcs32,
   output logic [2:0]             ack_length,
   output logic [7:0]             ack_seq_num,
   output logic                   ack_frame_pending,
   output logic [31:0]            ack_fcs
);

   logic [CTRL_WIDTH-1:0] ctrl;
   logic [15:0]           ack_delay;
   logic [3:0]            pending;
   logic [IRQ_WIDTH-1:0]  irq_status;
   logic [IRQ_WIDTH-1:0]  irq_enable;
   rfa_state_t            state;
   logic [15:0]           delay_cnt;
   logic [3:0]            unit_hit;
   logic                  ext_hit;
   logic                  ack_wanted;
   logic [IRQ_WIDTH-1:0]  irq_event;
   logic [31:0]           next_rdata;
   logic                  addr_ok;
   logic                  wr_access;
   logic [3:0]            addr_filter_unit_enable;
   logic                  filter_on;
   logic                  is_ack_frame;
   logic                  frame_passes;
   logic                  need_ack;
   logic                  fcs32_sel;
   logic                  pend_bit;
   logic [7:0]            fcf_lo;
   logic                  ack_frame_seen;
   logic                  arm_ack;
   logic                  ack_busy;

   function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ data[i]) begin
            c = (c >> 1) ^ CRC16_POLY;
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

   function automatic logic [31:0] crc32_byte(input logic [31:0] crc, input logic [7:0] data);
      logic [31:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         if (c[0] ^ data[i]) begin
            c = (c >> 1) ^ CRC32_POLY;
         end else begin
            c = c >> 1;
         end
      end
      return c;
   endfunction

   // Lowest-numbered enabled unit that matched supplies the pending bit.
   function automatic logic pick_pending(input logic [3:0] hits, input logic [3:0] pend);
      logic p;
      p = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         if (hits[i]) begin
            p = pend[i];
         end
      end
      return p;
   endfunction

   // Enabled units that matched; an acknowledgement frame never counts as a match.
   function automatic logic [3:0] units_hit(input logic [3:0] am, input logic [3:0] en, input logic ack);
      return ack ? 4'h0 : (am & en);
   endfunction

   // Extended match counts only with filtering on and never for an acknowledgement frame.
   function automatic logic ext_match(input logic em, input logic filt, input logic ack);
      return filt && !ack && em;
   endfunction

   assign addr_filter_unit_enable         = ctrl[CTRL_ADDR_FILTER_UNIT_ENABLE_LSB +: 4];
   assign filter_on    = |addr_filter_unit_enable;
   assign is_ack_frame = (rx_frame_type == FT_ACK);
   assign wr_access    = psel && penable && pready && pwrite;

   // Frame passes all stages: first level, then match or promiscuous when filtering. [RULE5] [RULE6] [RULE7]
   assign frame_passes = first_level_pass &&
                         (!filter_on || ack_frame_seen || (|unit_hit) || ext_hit || ctrl[CTRL_PROM]); // [RULE8]

   // Third-level match, data or command type, and acknowledgement requested. [RULE9]
   assign need_ack = ack_wanted && ctrl[CTRL_AUTO_ACKNOWLEDGE] && !ctrl[CTRL_TRANSMIT_THEN_LISTEN] && frame_passes; // [RULE15]
   assign arm_ack  = !ack_busy && rx_frame_done && need_ack;
   assign ack_busy = (state != RFA_IDLE);

   assign fcs32_sel = ctrl[CTRL_FCS_RX] ? rx_fcs32 : ctrl[CTRL_FCS32_CFG]; // [RULE14]
   assign pend_bit  = pick_pending(unit_hit, pending); // [RULE17]
   assign fcf_lo    = ACK_FCF_LO | (8'(pend_bit) << FCF_PEND_BIT);

   always_comb begin
      addr_ok    = 1'b1;
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         OFS_CTRL:       next_rdata = 32'(ctrl);
         OFS_ACK_DELAY:  next_rdata = 32'(ack_delay);
         OFS_PENDING:    next_rdata = 32'(pending);
         OFS_IRQ_STATUS: next_rdata = 32'(irq_status);
         OFS_IRQ_CLEAR:  next_rdata = 32'h0000_0000;
         OFS_IRQ_ENABLE: next_rdata = 32'(irq_enable);
         OFS_STATUS:     next_rdata = {16'h0000, ack_seq_num, 1'b0, transmit_prepare_state,
                                       ack_busy, ext_hit, unit_hit};
         default:        addr_ok    = 1'b0;
      endcase
   end

   // APB answer: one access cycle, data captured in the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
         end
      end
   end

   // Configuration registers written by software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl       <= CTRL_RST;
         ack_delay  <= ACK_DELAY_RST;
         pending    <= PENDING_RST;
         irq_enable <= IRQ_RST;
      end else if (wr_access) begin
         unique case (paddr)
            OFS_CTRL:       ctrl       <= pwdata[CTRL_WIDTH-1:0];
            OFS_ACK_DELAY:  ack_delay  <= pwdata[15:0]; // [RULE11]
            OFS_PENDING:    pending    <= pwdata[3:0];
            OFS_IRQ_ENABLE: irq_enable <= pwdata[IRQ_WIDTH-1:0];
            default:        ;
         endcase
      end
   end

   // Filter results latched once the header is parsed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_hit   <= 4'h0;
         ext_hit    <= 1'b0;
         ack_wanted <= 1'b0;
         ack_frame_seen <= 1'b0;
      end else if (rx_header_valid) begin
         unit_hit   <= 4'h0;
         ext_hit    <= 1'b0;
         ack_wanted <= 1'b0;
         ack_frame_seen <= 1'b0;
      end else if (rx_header_parsed) begin
         unit_hit   <= units_hit(addr_match_result, addr_filter_unit_enable, is_ack_frame); // [RULE2] [RULE6] [RULE8]
         ext_hit    <= ext_match(extended_match_result, filter_on, is_ack_frame); // [RULE3] [RULE6] [RULE8]
         ack_frame_seen <= is_ack_frame; // [RULE8]
         ack_wanted <= |units_hit(addr_match_result, addr_filter_unit_enable, is_ack_frame) && rx_ack_request &&
                       (rx_frame_type == FT_DATA || rx_frame_type == FT_CMD); // [RULE9]
      end
   end

   // Interrupt pulses toward the host.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_event <= IRQ_RST;
      end else begin
         irq_event[IRQ_RXFS] <= rx_header_valid; // [RULE1]
         irq_event[IRQ_RXAM] <= rx_header_parsed &&
                                |units_hit(addr_match_result, addr_filter_unit_enable, is_ack_frame); // [RULE2] [RULE8]
         irq_event[IRQ_RXEM] <= rx_header_parsed &&
                                ext_match(extended_match_result, filter_on, is_ack_frame); // [RULE3] [RULE8]
         irq_event[IRQ_RXFE] <= rx_frame_done && frame_passes; // [RULE4] [RULE5]
         irq_event[IRQ_TX_FRAME_END_IRQ] <= (state == RFA_SEND) && ack_tx_done; // [RULE19]
      end
   end

   always_comb begin
      rx_frame_start_irq    = irq_event[IRQ_RXFS];
      rx_address_match_irq  = irq_event[IRQ_RXAM];
      rx_extended_match_irq = irq_event[IRQ_RXEM];
      rx_frame_end_irq      = irq_event[IRQ_RXFE];
      tx_frame_end_irq      = irq_event[IRQ_TX_FRAME_END_IRQ];
   end

   // Sticky status: a new event wins over a clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= IRQ_RST;
      end else begin
         irq_status <= (irq_status & ~((wr_access && paddr == OFS_IRQ_CLEAR) ? pwdata[IRQ_WIDTH-1:0] :
                       IRQ_RST)) | irq_event;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((irq_status | irq_event) & irq_enable);
      end
   end

   // Acknowledgement sequencer: wait the programmed delay plus one cycle after frame end, then send.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state        <= RFA_IDLE;
         delay_cnt    <= 16'h0000;
         ack_tx_start <= 1'b0;
      end else begin
         ack_tx_start <= 1'b0;
         unique case (state)
            RFA_IDLE: begin
               if (arm_ack) begin
                  state     <= RFA_WAIT;
                  delay_cnt <= ack_delay; // [RULE18]
               end
            end
            RFA_WAIT: begin
               if (delay_cnt == 16'h0000) begin
                  ack_tx_start <= 1'b1; // [RULE18]
                  state        <= RFA_SEND;
               end else begin
                  delay_cnt <= delay_cnt - 16'h0001;
               end
            end
            RFA_SEND: begin
               if (ack_tx_done) begin
                  state <= RFA_IDLE; // [RULE19]
               end
            end
         endcase
      end
   end

   // With auto acknowledge on, a passed frame needing no acknowledgement rests in transmit-prepare.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_prepare_state <= 1'b0;
      end else if (rx_header_valid || !ctrl[CTRL_AUTO_ACKNOWLEDGE]) begin
         transmit_prepare_state <= 1'b0;
      end else if (rx_frame_done && frame_passes && !need_ack) begin
         transmit_prepare_state <= 1'b1; // [RULE19]
      end
   end

   // Acknowledgement frame description captured at frame end.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_from_buffer   <= 1'b0;
         ack_rate          <= '0;
         ack_fcs32         <= 1'b0;
         ack_length        <= ACK_LEN_FCS16;
         ack_seq_num       <= 8'h00;
         ack_frame_pending <= 1'b0;
         ack_fcs           <= 32'h0000_0000;
      end else if (arm_ack) begin
         ack_from_buffer   <= ctrl[CTRL_SRC_BUF]; // [RULE13]
         ack_rate          <= ctrl[CTRL_RATE_RX] ? rx_rate : tx_cfg_rate; // [RULE12]
         ack_fcs32         <= fcs32_sel; // [RULE14]
         ack_length        <= fcs32_sel ? ACK_LEN_FCS32 : ACK_LEN_FCS16; // [RULE16]
         ack_seq_num       <= rx_seq_num; // [RULE10] [RULE16]
         ack_frame_pending <= pend_bit; // [RULE17]
         if (fcs32_sel) begin
            ack_fcs <= ~crc32_byte(crc32_byte(crc32_byte(CRC32_INIT, fcf_lo), ACK_FCF_HI),
                                   rx_seq_num); // [RULE10]
         end else begin
            ack_fcs <= {16'h0000, crc16_byte(crc16_byte(crc16_byte(16'h0000, fcf_lo), ACK_FCF_HI),
                                             rx_seq_num)}; // [RULE10]
         end
      end
   end

endmodule

// ===== testbench/rfa_monitor.sv
// Purpose: Port checker for the receive interrupt and acknowledgement block.
// Assumes: One clock domain, reset active low.
// Notes:   Attached to rfa_core by bind.
`timescale 1ns/10ps
module rfa_monitor
   import rfa_pkg::*;
(
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       rx_header_valid,
   input wire logic       rx_header_parsed,
   input wire logic       extended_match_result,
   input wire logic [2:0] rx_frame_type,
   input wire logic       rx_frame_done,
   input wire logic       first_level_pass,
   input wire logic       ack_tx_done,
   input wire logic       rx_frame_start_irq,
   input wire logic       rx_address_match_irq,
   input wire logic       rx_extended_match_irq,
   input wire logic       rx_frame_end_irq,
   input wire logic       tx_frame_end_irq,
   input wire logic       ack_tx_start,
   input wire logic       ack_from_buffer,
   input wire logic       ack_fcs32,
   input wire logic [2:0] ack_length
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   fs_pulse_a: assert property (rx_header_valid |=> rx_frame_start_irq)
      else $error("frame start pulse missing");
   fs_cause_a: assert property (rx_frame_start_irq |-> $past(rx_header_valid))
      else $error("frame start pulse without header");
   am_cause_a: assert property (rx_address_match_irq |->
                                $past(rx_header_parsed) && $past(rx_frame_type) != FT_ACK)
      else $error("address match pulse without parsed header");
   em_cause_a: assert property (rx_extended_match_irq |-> $past(rx_header_parsed && extended_match_result))
      else $error("extended match pulse without extended result");
   ack_nomatch_a: assert property (rx_header_parsed && rx_frame_type == FT_ACK |=>
                                   !(rx_address_match_irq || rx_extended_match_irq))
      else $error("match pulse for an acknowledgement frame");
   fe_cause_a: assert property (rx_frame_end_irq |-> $past(rx_frame_done && first_level_pass))
      else $error("frame end pulse without passed frame");
   fe_block_a: assert property (rx_frame_done && !first_level_pass |=> !rx_frame_end_irq)
      else $error("frame end pulse after failed first level");
   tx_frame_end_irq_pulse_a: assert property (ack_tx_done |=> tx_frame_end_irq)
      else $error("transmit end pulse missing");
   ack_len_a: assert property (ack_tx_start && !ack_from_buffer |->
                               ack_length == (ack_fcs32 ? ACK_LEN_FCS32 : ACK_LEN_FCS16))
      else $error("acknowledgement length does not fit checksum");
   start_once_a: assert property (ack_tx_start |=> !ack_tx_start)
      else $error("acknowledgement start longer than one cycle");
   fe_seen_c: cover property (rx_frame_end_irq);
   ack_seen_c: cover property (ack_tx_start);
   tx_frame_end_irq_seen_c: cover property (tx_frame_end_irq);
endmodule
bind rfa_core rfa_monitor u_rfa_monitor (.pclk, .presetn, .rx_header_valid, .rx_header_parsed,
   .extended_match_result, .rx_frame_type, .rx_frame_done, .first_level_pass, .ack_tx_done,
   .rx_frame_start_irq, .rx_address_match_irq, .rx_extended_match_irq, .rx_frame_end_irq,
   .tx_frame_end_irq, .ack_tx_start, .ack_from_buffer, .ack_fcs32, .ack_length);

// ===== testbench/rfa_tx_model.sv
// Purpose: Transmitter that sends the acknowledgement and reports completion.
// Assumes: Start is a one-cycle pulse.
// Notes:   Latency lat lets it answer promptly or slowly.
`timescale 1ns/10ps
module rfa_tx_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ack_tx_start,
   input  wire logic [7:0] lat,
   output logic            ack_tx_done
);
   logic [8:0] left;
   // Counts the frame out, then gives one done pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left        <= 9'h000;
         ack_tx_done <= 1'b0;
      end else begin
         ack_tx_done <= (left == 9'h001);
         if (ack_tx_start)
            left <= {1'b0, lat} + 9'h001;
         else if (left != 9'h000)
            left <= left - 9'h001;
      end
   end
endmodule

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the receive interrupt and acknowledgement block.
// Assumes: APB answers within the bench timeout.
// Notes:   Filter cases are table rows; acknowledgement and registers are hand tests.
`timescale 1ns/10ps
module testbench
   import rfa_pkg::*;
;
   localparam int D = 3;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr, rx_seq_num, ack_seq_num, lat;
   logic [31:0] pwdata, prdata, ack_fcs;
   logic        rx_header_valid, rx_header_parsed, extended_match_result, rx_ack_request;
   logic        rx_fcs32, rx_frame_done, first_level_pass, ack_tx_done, ack_tx_start;
   logic [3:0]  addr_match_result, rx_rate, tx_cfg_rate, ack_rate, got;
   logic [2:0]  rx_frame_type, ack_length;
   logic        rx_frame_start_irq, rx_address_match_irq, rx_extended_match_irq, rx_frame_end_irq;
   logic        tx_frame_end_irq, transmit_prepare_state, ack_from_buffer, ack_fcs32, ack_frame_pending;
   logic        err;
   logic [31:0] v;
   int          checks, mismatches, cyc, i;
   // Nibbles: unit enables, match results, {ext, promiscuous, first level, ack frame}, expected irqs.
   logic [15:0] rows [11] = '{16'h0fc8, 16'h0029, 16'h1008, 16'h118e, 16'h1028, 16'h1069,
                              16'h10ab, 16'h222d, 16'h1228, 16'h11b9, 16'hffef};
   rfa_core u_rfa_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rx_header_valid, .rx_header_parsed, .addr_match_result, .extended_match_result,
      .rx_frame_type, .rx_ack_request, .rx_seq_num, .rx_fcs32, .rx_rate, .tx_cfg_rate, .rx_frame_done,
      .first_level_pass, .ack_tx_done, .rx_frame_start_irq, .rx_address_match_irq,
      .rx_extended_match_irq, .rx_frame_end_irq, .tx_frame_end_irq, .irq, .transmit_prepare_state,
      .ack_tx_start, .ack_from_buffer, .ack_rate, .ack_fcs32, .ack_length, .ack_seq_num,
      .ack_frame_pending, .ack_fcs);
   rfa_tx_model u_rfa_tx_model (.pclk, .presetn, .ack_tx_start, .lat, .ack_tx_done);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task conclude;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         mismatches++;
         conclude();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, v, err);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, v, err);
      chk(v, exp);
   endtask
   function automatic logic [31:0] fcs_ref(input logic [31:0] poly, input logic [31:0] c, input logic [7:0] seq);
      logic [23:0] b;
      b = {seq, ACK_FCF_HI, ACK_FCF_LO | (8'h01 << FCF_PEND_BIT)};
      for (int k = 0; k < 24; k++)
         c = (c[0] ^ b[k]) ? ((c >> 1) ^ poly) : (c >> 1);
      return c;
   endfunction
   task frame(input logic [3:0] am, input logic em, input logic [2:0] ft, input logic req, input logic flp);
      @(posedge pclk) rx_header_valid <= 1'b1;
      @(posedge pclk) rx_header_valid <= 1'b0;
      #1 got[3] = rx_frame_start_irq;
      @(posedge pclk) rx_header_parsed <= 1'b1;
      {addr_match_result, extended_match_result, rx_frame_type, rx_ack_request} <= {am, em, ft, req};
      @(posedge pclk) rx_header_parsed <= 1'b0;
      #1 got[2:1] = {rx_address_match_irq, rx_extended_match_irq};
      @(posedge pclk) rx_frame_done <= 1'b1;
      first_level_pass <= flp;
      @(posedge pclk) rx_frame_done <= 1'b0;
      #1 got[0] = rx_frame_end_irq;
   endtask
   task ack_case(input logic [31:0] ctrl, input logic [2:0] ft, input logic [7:0] seq, input logic [2:0] len,
                 input logic [3:0] rate, input logic buf_src);
      int n;
      wr(OFS_CTRL, ctrl);
      rx_seq_num <= seq;
      frame(4'h1, 1'b0, ft, 1'b1, 1'b1);
      n = 0;
      while (ack_tx_start !== 1'b1 && n < 100) begin
         @(posedge pclk);
         #1 n++;
      end
      chk(n, D + 1);
      chk(ack_seq_num, seq);
      chk(ack_length, len);
      chk(ack_rate, rate);
      chk(ack_from_buffer, buf_src);
      chk(ack_frame_pending, 1'b1);
      chk(ack_fcs32, len == ACK_LEN_FCS32);
      chk(ack_fcs, (len == ACK_LEN_FCS32) ? ~fcs_ref(CRC32_POLY, CRC32_INIT, seq)
                                           : fcs_ref(32'(CRC16_POLY), 32'h0, seq));
      n = 0;
      while (tx_frame_end_irq !== 1'b1 && n < 100) begin
         @(posedge pclk);
         #1 n++;
      end
      chk(tx_frame_end_irq, 1'b1);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, rx_header_valid, rx_header_parsed} = '0;
      {addr_match_result, extended_match_result, rx_frame_type, rx_ack_request, rx_frame_done} = '0;
      {first_level_pass, rx_seq_num, checks, mismatches, cyc} = '0;
      {rx_fcs32, rx_rate, tx_cfg_rate, lat} = {1'b1, 4'h9, 4'h3, 8'h00};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk(ack_length, ACK_LEN_FCS16);
      for (i = 0; i < 7; i++)
         rd(8'(i * 4), 32'h0);
      for (i = 0; i < 11; i++) begin
         wr(OFS_CTRL, {27'h0, rows[i][6], rows[i][15:12]});
         frame(rows[i][11:8], rows[i][7], rows[i][4] ? FT_ACK : FT_DATA, 1'b0, rows[i][5]);
         chk(got, rows[i][3:0]);
      end
      apb(1'b0, 8'h1c, 32'h0, v, err);
      chk(err, 1'b1);
      chk(v, 32'h0);
      wr(OFS_IRQ_CLEAR, 32'h1f);
      wr(OFS_IRQ_ENABLE, 32'h1);
      @(posedge pclk) #1 chk(irq, 1'b0);
      wr(OFS_CTRL, 32'h0);
      frame(4'h0, 1'b0, FT_DATA, 1'b0, 1'b0);
      chk(irq, 1'b1);
      rd(OFS_IRQ_STATUS, 32'h1);
      wr(OFS_IRQ_ENABLE, 32'h0);
      @(posedge pclk) #1 chk(irq, 1'b0);
      wr(OFS_IRQ_ENABLE, 32'h1);
      @(posedge pclk) #1 chk(irq, 1'b1);
      wr(OFS_IRQ_CLEAR, 32'h1);
      @(posedge pclk) #1 chk(irq, 1'b0);
      rd(OFS_IRQ_STATUS, 32'h0);
      wr(OFS_ACK_DELAY, D);
      rd(OFS_ACK_DELAY, D);
      wr(OFS_PENDING, 32'h1);
      ack_case(32'h21, FT_DATA, 8'h5a, ACK_LEN_FCS16, 4'h3, 1'b0);
      lat <= 8'd20;
      ack_case(32'h1e1, FT_CMD, 8'ha5, ACK_LEN_FCS32, 4'h9, 1'b1);
      ack_case(32'h221, FT_DATA, 8'h3c, ACK_LEN_FCS32, 4'h3, 1'b0);
      wr(OFS_CTRL, 32'h21);
      frame(4'h1, 1'b0, 3'h0, 1'b0, 1'b1);
      chk(got, 4'hd);
      #5 chk(transmit_prepare_state, 1'b1);
      wr(OFS_CTRL, 32'h421);
      frame(4'h1, 1'b0, FT_DATA, 1'b1, 1'b1);
      for (i = 0; i < 20 && ack_tx_start !== 1'b1; i++)
         @(posedge pclk) #1;
      chk(i, 20);
      @(posedge pclk) presetn <= 1'b0;
      #1 chk(32'({irq, transmit_prepare_state, ack_tx_start, ack_length}), 32'h5);
      @(posedge pclk) presetn <= 1'b1;
      rd(OFS_CTRL, 32'h0);
      conclude();
   end
endmodule
